// [tmc_params.svh]
// register map, field positions, reset values and timing counts of the timer block
`ifndef TMC_PARAMS_SVH
`define TMC_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define TMC_OFF_CTRL     8'h00
`define TMC_OFF_CNT_LO   8'h04
`define TMC_OFF_CNT_HI   8'h08
`define TMC_OFF_STATUS   8'h0C
`define TMC_OFF_MASK     8'h10

// ----------------------------------------------------------------------
// timer_control fields, and the overflow bit of status and mask
// ----------------------------------------------------------------------
`define TMC_B_RUN        0
`define TMC_B_CS         1
`define TMC_B_BYPASS     2
`define TMC_B_OSC_EN     3
`define TMC_B_PS_LO      4
`define TMC_B_PS_HI      5
`define TMC_B_SYSCLK     6
`define TMC_B_WIDE       7
`define TMC_B_OVF        0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define TMC_RST_BYTE     8'h00
`define TMC_RST_COUNT    16'h0000
`define TMC_COUNT_MAX    16'hFFFF

// ----------------------------------------------------------------------
// timing: instruction cycle is the core clock divided by four
// ----------------------------------------------------------------------
`define TMC_INSTR_DIV    4
`define TMC_INSTR_LAST   2'h3

`endif

// [tmc_pkg.sv]
// types of the timer block: bus phase and the whole module state
package tmc_pkg;

    typedef enum logic [1:0] {
        TMC_BUS_IDLE = 2'b01,
        TMC_BUS_ACC  = 2'b10
    } tmc_bus_t;

    typedef struct packed {
        tmc_bus_t    bus;
        logic [7:0]  a_off;
        logic        a_wr;
        logic        a_sel;
        logic        hready;
        logic [31:0] hrdata;
        logic        run;
        logic        cs;
        logic        bypass;
        logic        osc_en;
        logic [1:0]  ps;
        logic        sysclk;
        logic        wide;
        logic [15:0] count;
        logic [7:0]  hbuf;
        logic [2:0]  pre;
        logic [1:0]  div;
        logic        pend;
        logic        src_prev;
        logic [1:0]  pin_s1;
        logic [1:0]  pin_s2;
        logic        status;
        logic        mask;
        logic        irq;
        logic [1:0]  pin_oe;
        logic [1:0]  pin_rd;
    } tmc_state_t;

endpackage

// [tmc_timer.sv]
// sixteen bit timer/counter with prescaler, wide access buffer and ahb-lite slave
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/10ps

`include "tmc_params.svh"

module tmc_timer (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic [1:0]  port_pin_in,
    input  wire logic [1:0]  port_direction,
    input  wire logic        sysclk_is_lp_osc,
    input  wire logic        special_event_trig,
    output logic [1:0]       port_pin_oe,
    output logic [1:0]       port_pin_read,
    output logic             lp_osc_amp_en,
    output logic             overflow_irq
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    tmc_pkg::tmc_state_t st;
    tmc_pkg::tmc_state_t next_st;

    logic       src;
    logic       edge_ext;
    logic       instr;
    logic       src_evt;
    logic       tick;
    logic       cnt_wr;
    logic       trig_ok;
    logic       ovf;
    logic       take;
    logic       acc;
    logic [2:0] pmask;
    logic [7:0] rd_byte;

    // prescale mask: ratio minus one
    function automatic logic [2:0] ps_mask(input logic [1:0] sel);
        case (sel)
            2'h0:    ps_mask = 3'h0;
            2'h1:    ps_mask = 3'h1;
            2'h2:    ps_mask = 3'h3;
            default: ps_mask = 3'h7;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st  = st;
        rd_byte  = `TMC_RST_BYTE;
        cnt_wr   = 1'b0;
        tick     = 1'b0;
        ovf      = 1'b0;

        // pins pass two flops before use
        next_st.pin_s1 = port_pin_in;
        next_st.pin_s2 = st.pin_s1;

        // source pick: oscillator pin when it is on, else count pin
        src              = st.osc_en ? st.pin_s2[1] : st.pin_s2[0];
        next_st.src_prev = src;
        edge_ext         = src & ~st.src_prev;

        // instruction cycle enable from the core clock
        next_st.div = st.div + 2'h1;
        instr       = (st.div == `TMC_INSTR_LAST);

        // mode select: sync mode holds an edge until the next instruction cycle
        src_evt = 1'b0;
        if (!st.cs) begin
            src_evt      = instr;
            next_st.pend = 1'b0;
        end else if (st.bypass) begin
            src_evt      = edge_ext;
            next_st.pend = 1'b0;
        end else begin
            src_evt      = instr & (st.pend | edge_ext);
            next_st.pend = (st.pend | edge_ext) & ~instr;
        end
        if (!st.run) begin
            src_evt      = 1'b0;
            next_st.pend = 1'b0;
        end

        // prescaler
        pmask = ps_mask(st.ps);
        if (src_evt) begin
            if ((st.pre & pmask) == pmask) begin
                next_st.pre = 3'h0;
                tick        = 1'b1;
            end else begin
                next_st.pre = st.pre + 3'h1;
            end
        end

        // --------------------------------------------------------------
        // ahb-lite slave: one wait state, access done in the data phase
        // --------------------------------------------------------------
        take = hsel & htrans[1] & hready & (st.bus == tmc_pkg::TMC_BUS_IDLE);
        acc  = (st.bus == tmc_pkg::TMC_BUS_ACC);
        unique case (st.bus)
            tmc_pkg::TMC_BUS_IDLE: begin
                if (take) begin
                    next_st.a_off  = haddr[7:0];
                    next_st.a_wr   = hwrite;
                    next_st.a_sel  = (haddr[31:8] == 24'h000000);
                    next_st.hready = 1'b0;
                    next_st.bus    = tmc_pkg::TMC_BUS_ACC;
                end
            end
            tmc_pkg::TMC_BUS_ACC: begin
                next_st.hready = 1'b1;
                next_st.bus    = tmc_pkg::TMC_BUS_IDLE;
            end
            default: begin
                next_st.hready = 1'b1;
                next_st.bus    = tmc_pkg::TMC_BUS_IDLE;
            end
        endcase

        if (acc && st.a_sel && st.a_wr) begin
            case (st.a_off)
                `TMC_OFF_CTRL: begin
                    next_st.run    = hwdata[`TMC_B_RUN];
                    next_st.cs     = hwdata[`TMC_B_CS];
                    next_st.bypass = hwdata[`TMC_B_BYPASS];
                    next_st.osc_en = hwdata[`TMC_B_OSC_EN];
                    next_st.ps     = hwdata[`TMC_B_PS_HI:`TMC_B_PS_LO];
                    next_st.wide   = hwdata[`TMC_B_WIDE];
                end
                `TMC_OFF_CNT_LO: begin
                    next_st.count[7:0] = hwdata[7:0];
                    if (st.wide) begin
                        next_st.count[15:8] = st.hbuf;
                    end
                    next_st.pre = 3'h0;
                    cnt_wr      = 1'b1;
                end
                `TMC_OFF_CNT_HI: begin
                    if (st.wide) begin
                        next_st.hbuf = hwdata[7:0];
                    end else begin
                        next_st.count[15:8] = hwdata[7:0];
                        cnt_wr              = 1'b1;
                    end
                end
                `TMC_OFF_STATUS: next_st.status = st.status & ~hwdata[`TMC_B_OVF];
                `TMC_OFF_MASK:   next_st.mask = hwdata[`TMC_B_OVF];
                default: ;
            endcase
        end

        if (acc && st.a_sel && !st.a_wr) begin
            case (st.a_off)
                `TMC_OFF_CTRL: begin
                    rd_byte = {st.wide, st.sysclk, st.ps, st.osc_en,
                               st.bypass, st.cs, st.run};
                end
                `TMC_OFF_CNT_LO: begin
                    rd_byte = st.count[7:0];
                    if (st.wide) begin
                        next_st.hbuf = st.count[15:8];
                    end
                end
                `TMC_OFF_CNT_HI: rd_byte = st.wide ? st.hbuf : st.count[15:8];
                `TMC_OFF_STATUS: rd_byte = {7'h00, st.status};
                `TMC_OFF_MASK:   rd_byte = {7'h00, st.mask};
                default:         rd_byte = `TMC_RST_BYTE;
            endcase
            next_st.hrdata = {24'h000000, rd_byte};
        end

        // --------------------------------------------------------------
        // counter: write beats trigger, trigger beats increment
        // --------------------------------------------------------------
        // trigger is unreliable against an unsynchronised source, so it is ignored there
        trig_ok = special_event_trig & ~(st.cs & st.bypass);
        if (!cnt_wr) begin
            if (trig_ok) begin
                next_st.count = `TMC_RST_COUNT;
            end else if (tick) begin
                next_st.count = st.count + 16'h0001;
                ovf           = (st.count == `TMC_COUNT_MAX);
            end
        end

        // set wins over a coincident one-write clear
        if (ovf) begin
            next_st.status = 1'b1;
        end
        next_st.irq = next_st.status & next_st.mask;

        next_st.sysclk = sysclk_is_lp_osc;

        // running timer owns the pins: inputs, reading zero
        next_st.pin_oe = next_st.run ? 2'h0 : ~port_direction;
        next_st.pin_rd = next_st.run ? 2'h0 : st.pin_s2;
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st        <= '0;
            st.bus    <= tmc_pkg::TMC_BUS_IDLE;
            st.hready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign hreadyout     = st.hready;
    assign hrdata        = st.hrdata;
    assign hresp         = 1'b0;
    assign port_pin_oe   = st.pin_oe;
    assign port_pin_read = st.pin_rd;
    assign lp_osc_amp_en = st.osc_en;
    assign overflow_irq  = st.irq;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic wr_lo;
    logic rd_lo;
    logic wr_hi;
    assign wr_lo = acc & st.a_sel & st.a_wr & (st.a_off == `TMC_OFF_CNT_LO);
    assign rd_lo = acc & st.a_sel & ~st.a_wr & (st.a_off == `TMC_OFF_CNT_LO);
    assign wr_hi = acc & st.a_sel & st.a_wr & (st.a_off == `TMC_OFF_CNT_HI);

    a_stop_no_count: assert property (
        (!st.run && !cnt_wr && !trig_ok) |=> $stable(st.count))
        else $error("count moved while stopped");

    a_timer_on_instr: assert property (
        (tick && !st.cs) |-> (st.div == `TMC_INSTR_LAST))
        else $error("timer step off the instruction cycle");

    a_async_on_edge: assert property (
        (src_evt && st.cs && st.bypass) |-> (src && !st.src_prev))
        else $error("async step without a rising edge");

    a_sync_aligned: assert property (
        (src_evt && st.cs && !st.bypass) |-> instr)
        else $error("sync step not aligned");

    a_pins_quiet: assert property (
        st.run |-> (port_pin_read == 2'h0 && port_pin_oe == 2'h0))
        else $error("pins not released while running");

    a_wide_snapshot: assert property (
        (rd_lo && st.wide) |=> (st.hbuf == $past(st.count[15:8])))
        else $error("high byte not captured on low read");

    a_wide_load: assert property (
        (wr_lo && st.wide) |=> (st.count[15:8] == $past(st.hbuf)))
        else $error("high byte not loaded from buffer");

    a_pre_clear: assert property (
        wr_lo |=> (st.pre == 3'h0))
        else $error("prescaler not cleared");

    a_ovf_flag: assert property (
        (tick && !cnt_wr && !trig_ok && st.count == `TMC_COUNT_MAX)
        |=> (st.status && st.count == `TMC_RST_COUNT && overflow_irq == st.mask))
        else $error("rollover did not flag");

    a_trig_zero: assert property (
        (trig_ok && !cnt_wr && !st.status) |=> (st.count == `TMC_RST_COUNT && !st.status))
        else $error("trigger did not zero count");

    a_bus_one_wait: assert property (
        take |=> (!hreadyout ##1 hreadyout))
        else $error("data phase not one wait state");

    a_ctrl_write: assert property (
        (acc && st.a_sel && st.a_wr && st.a_off == `TMC_OFF_CTRL)
        |=> (st.run == $past(hwdata[`TMC_B_RUN])))
        else $error("run bit not written");

    a_wide_buf_wr: assert property (
        (wr_hi && st.wide) |=> (st.hbuf == $past(hwdata[7:0])))
        else $error("high byte write missed the buffer");

    a_hi_keeps_pre: assert property (
        (wr_hi && !src_evt) |=> $stable(st.pre))
        else $error("high byte write touched the prescaler");

    a_ps_one_ratio: assert property (
        (src_evt && st.ps == 2'h0) |-> tick)
        else $error("undivided source missed a step");

    a_count_step: assert property (
        (tick && !cnt_wr && !trig_ok) |=> (st.count == $past(st.count) + 16'h0001))
        else $error("count did not step by one");

    a_sysclk_track: assert property (
        1'b1 |=> (st.sysclk == $past(sysclk_is_lp_osc)))
        else $error("clock status bit lags");

    a_rdata_hold: assert property (
        !(acc && !st.a_wr) |=> $stable(hrdata))
        else $error("read data moved without a read");

    c_rollover: cover property (ovf);
    c_wide_read: cover property (rd_lo && st.wide);
    c_trigger: cover property (trig_ok && st.run);
    c_irq: cover property (overflow_irq);
    c_sync_count: cover property (src_evt && st.cs && !st.bypass);

endmodule

// [tmc_pin_src.sv]
// partner model: external count pin and low-power crystal feeding the timer pins
`timescale 1ns/10ps

module tmc_pin_src (
    input  wire logic       hclk,
    input  wire logic       lp_osc_amp_en,
    output logic      [1:0] pins
);
    // ------------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------------
    initial pins = 2'b00;

    // both pins rest low between bursts; half period of 6 cycles is slower than one tick
    task automatic burst(input int n, input int sel);
        for (int i = 0; i < 2 * n; i++) begin
            repeat (6) @(posedge hclk);
            if (sel == 0 || lp_osc_amp_en) begin
                pins[sel] <= ~pins[sel];
            end
        end
    endtask
endmodule

// [tb_top.sv]
// self-checking bench of the timer block with a behavioural register model
`timescale 1ns/10ps

module tb_top;
    // ------------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------------
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic [1:0]  pins;
    logic [1:0]  pdir = 2'b11;
    logic        sys_lp = 1'b0;
    logic        trig = 1'b0;
    logic [1:0]  oe;
    logic [1:0]  prd;
    logic        amp;
    logic        irq;
    logic [31:0] seed = 32'h000058A9;
    int          n_mismatch = 0;
    int          compares = 0;
    int          m_ctrl = 0, m_cnt = 0, m_hbuf = 0, m_stat = 0, m_mask = 0, m_pre = 0;
    int          cf[5] = '{6, 2, 22, 10, 2};
    int          sl[5] = '{0, 0, 0, 1, 1};

    always #10 hclk = ~hclk;

    tmc_timer tmc_timer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .port_pin_in(pins), .port_direction(pdir), .sysclk_is_lp_osc(sys_lp),
        .special_event_trig(trig), .port_pin_oe(oe), .port_pin_read(prd),
        .lp_osc_amp_en(amp), .overflow_irq(irq));
    tmc_pin_src tmc_pin_src_i (.hclk(hclk), .lp_osc_amp_en(amp), .pins(pins));

    // ------------------------------------------------------------------
    // behavioural model
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    function automatic void m_step(int n);
        for (int i = 0; i < n; i++) begin
            m_pre++;
            if (m_pre >= (1 << ((m_ctrl >> 4) & 3))) begin
                m_pre = 0;
                m_cnt = (m_cnt + 1) & 65535;
                if (m_cnt == 0) m_stat = 1;
            end
        end
    endfunction

    function automatic void m_wr(int a, int d);
        d = d & 255;
        case (a)
            0: m_ctrl = d & 191;
            4: begin
                m_cnt = m_ctrl[7] ? (m_hbuf << 8) | d : (m_cnt & 65280) | d;
                m_pre = 0;
            end
            8: if (m_ctrl[7]) m_hbuf = d; else m_cnt = (m_cnt & 255) | (d << 8);
            12: if (d[0]) m_stat = 0;
            16: m_mask = d & 1;
            default: ;
        endcase
    endfunction

    function automatic int m_rd(int a);
        case (a)
            0: return m_ctrl | (int'(sys_lp) << 6);
            4: begin
                if (m_ctrl[7]) m_hbuf = m_cnt >> 8;
                return m_cnt & 255;
            end
            8: return m_ctrl[7] ? m_hbuf : m_cnt >> 8;
            12: return m_stat;
            16: return m_mask;
            default: return 0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // bus master and checks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_rdy(output logic [31:0] q);
        logic r;
        r = 1'b0;
        while (r !== 1'b1) begin
            @(negedge hclk);
            r = hreadyout;
            q = hrdata;
            @(posedge hclk);
        end
    endtask

    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h000000, a};
        hwrite <= w;
        wait_rdy(q);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy(q);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        xfer(a, 1'b1, {24'h000000, d}, q);
        m_wr(a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        logic [31:0] q;
        xfer(a, 1'b0, 32'h00000000, q);
        chk(q, 32'(m_rd(a)));
        chk({31'h0, hresp}, 32'h00000000);
    endtask

    task automatic chk_out(input logic got, input logic exp);
        @(negedge hclk);
        chk({31'h0, got}, {31'h0, exp});
        @(posedge hclk);
    endtask

    // run window of exactly len cycles between the two applying edges
    task automatic run_window(input int c, input int len);
        pdir <= 2'(lfsr());
        wr(8'h00, 8'(c | 1));
        @(negedge hclk);
        chk({28'h0, oe, prd}, 32'h00000000);
        repeat (len - 3) @(posedge hclk);
        wr(8'h00, 8'(c));
        m_step(len / 4);
        @(negedge hclk);
        chk({30'h0, oe}, {30'h0, ~pdir});
        @(posedge hclk);
    endtask

    task automatic print_verdict();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge hclk);
        n_mismatch++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int a = 0; a <= 32; a += 4) rd(8'(a));
        chk_out(irq, 1'b0);
        wr(8'h00, 8'hFF);
        chk_out(amp, 1'b1);
        sys_lp <= 1'b1;
        rd(8'h00);
        sys_lp <= 1'b0;
        rd(8'h00);
        wr(8'h00, 8'h00);
        chk_out(amp, 1'b0);
        for (int p = 0; p < 4; p++) begin
            wr(8'h08, 8'h00);
            wr(8'h04, 8'h00);
            run_window((p << 4) | ((p & 1) << 2), 40 << p);
            rd(8'h04);
            repeat (40) @(posedge hclk);
            rd(8'h04);
        end
        for (int k = 0; k < 5; k++) begin
            wr(8'h04, 8'h00);
            wr(8'h00, 8'(cf[k] | 1));
            tmc_pin_src_i.burst(12, sl[k]);
            repeat (20) @(posedge hclk);
            wr(8'h00, 8'(cf[k]));
            m_step(((sl[k] == 1) == cf[k][3]) ? 12 : 0);
            rd(8'h04);
        end
        wr(8'h00, 8'h80);
        wr(8'h08, 8'(lfsr()));
        rd(8'h08);
        wr(8'h04, 8'(lfsr()));
        wr(8'h00, 8'h00);
        rd(8'h08);
        wr(8'h08, 8'(lfsr()));
        rd(8'h08);
        rd(8'h04);
        wr(8'h00, 8'h80);
        wr(8'h08, 8'(lfsr()));
        rd(8'h08);
        rd(8'h04);
        rd(8'h08);
        wr(8'h00, 8'h00);
        wr(8'h04, 8'h00);
        run_window(48, 16);
        wr(8'h08, 8'h00);
        run_window(48, 16);
        rd(8'h04);
        run_window(48, 16);
        wr(8'h04, 8'h00);
        run_window(48, 16);
        rd(8'h04);
        wr(8'h08, 8'hFF);
        wr(8'h04, 8'hFC);
        run_window(0, 40);
        rd(8'h0C);
        rd(8'h04);
        rd(8'h08);
        chk_out(irq, 1'b0);
        wr(8'h10, 8'h01);
        chk_out(irq, 1'b1);
        wr(8'h10, 8'h00);
        chk_out(irq, 1'b0);
        wr(8'h10, 8'h01);
        wr(8'h0C, 8'h01);
        chk_out(irq, 1'b0);
        rd(8'h0C);
        trig <= 1'b1;
        @(posedge hclk);
        trig <= 1'b0;
        m_cnt = 0;
        repeat (3) @(posedge hclk);
        rd(8'h04);
        rd(8'h08);
        rd(8'h0C);
        print_verdict();
    end
endmodule
